// ### core/memory_selftest_ctrl.sv
// Data RAM self-test controller: control register, reset sequencing and result flags.
`default_nettype none
`include "selftest_defines.svh"

module memory_selftest_ctrl
  import selftest_pkg::*;
#(
  parameter int ADDR_W = `RAM_ADDR_W,
  parameter int DATA_W = `RAM_DATA_W
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sw_reset_i,
  input wire logic config_loaded_i,
  input wire logic startup_selftest_disable_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_data_i,
  input wire logic ctl_wr_i,
  input wire selftest_pkg::ctl_word_t ctl_wdata_i,
  input wire logic [DATA_W-1:0] ram_rdata_i,
  output selftest_pkg::ctl_word_t ctl_rdata_o,
  output logic cpu_hold_o,
  output logic test_clk_req_o,
  output logic [ADDR_W-1:0] ram_addr_o,
  output logic [DATA_W-1:0] ram_wdata_o,
  output logic ram_we_o,
  output logic ram_re_o
);

  // ==========================================================================
  // State and submodules

  typedef struct packed {
    ctl_state_e state;
    logic arm;
    logic fault_inject;
    logic done_flag;
    logic fail_flag;
    logic runtime;
    logic eng_start;
    logic cpu_hold;
    logic clk_req;
    ctl_word_t rdata;
  } ctl_regs_s;

  ctl_regs_s st;
  ctl_regs_s next_st;
  logic unlocked;
  logic eng_busy;
  logic eng_done;
  logic eng_fail;
  logic ctl_write_ok;
  logic new_arm;
  logic new_inject;

  unlock_key u_key (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .key_wr_i(key_wr_i),
    .key_data_i(key_data_i),
    .consume_i(ctl_wr_i),
    .unlocked_o(unlocked)
  );

  march_engine #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_engine (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(st.eng_start),
    .ram_rdata_i(ram_rdata_i),
    .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o),
    .ram_we_o(ram_we_o),
    .ram_re_o(ram_re_o),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .fail_o(eng_fail)
  );

  // ==========================================================================
  // Control register write filter

  // Bits newly going from 0 to 1 in this write
  assign new_arm = ctl_wdata_i[`CTL_ARM_BIT] & ~st.arm;
  assign new_inject = ctl_wdata_i[`CTL_INJECT_BIT] & ~st.fault_inject;
  // Locked writes and writes setting two bits at once are dropped whole
  assign ctl_write_ok = ctl_wr_i && unlocked && (st.state == C_RUN)
                        && !(new_arm && new_inject);

  // ==========================================================================
  // Sequencer and flags

  always_comb
  begin
    next_st = st;
    next_st.eng_start = 1'b0;
    unique case (st.state)
      C_CFG_WAIT:
      begin
        // Power-on path: nothing runs until the configuration words are in
        if (config_loaded_i)
        begin
          if (startup_selftest_disable_i)
          begin
            next_st.state = C_RUN;
          end
          else
          begin
            next_st.state = C_TEST;
            next_st.eng_start = 1'b1;
            next_st.runtime = 1'b0;
          end
        end
      end
      C_TEST:
      begin
        // A software reset mid-test is ignored; the processor is held anyway
        if (eng_done)
        begin
          next_st.state = C_RUN;
          next_st.done_flag = 1'b1;
          next_st.fail_flag = eng_fail | (st.runtime & st.fault_inject);
          next_st.arm = 1'b0;
        end
      end
      C_RUN:
      begin
        if (sw_reset_i)
        begin
          if (st.arm)
          begin
            next_st.state = C_TEST;
            next_st.eng_start = 1'b1;
            next_st.runtime = 1'b1;
          end
          else
          begin
            next_st.state = C_RST;
          end
        end
        else if (ctl_write_ok)
        begin
          next_st.arm = ctl_wdata_i[`CTL_ARM_BIT];
          next_st.fault_inject = ctl_wdata_i[`CTL_INJECT_BIT];
        end
      end
      C_RST:
      begin
        // Plain software reset: one held cycle, flags untouched
        next_st.state = C_RUN;
      end
    endcase
    // Processor stays held outside the run state and sees flags already final
    next_st.cpu_hold = (next_st.state != C_RUN);
    // Test clock source must come from oscillator plus PLL while testing
    next_st.clk_req = (next_st.state == C_TEST);
    next_st.rdata = `CTL_RESET_VALUE;
    next_st.rdata[`CTL_ARM_BIT] = next_st.arm;
    next_st.rdata[`CTL_FAIL_BIT] = next_st.fail_flag;
    next_st.rdata[`CTL_DONE_BIT] = next_st.done_flag;
    next_st.rdata[`CTL_INJECT_BIT] = next_st.fault_inject;
  end

  // reset_i is the true power-on reset; only it clears done, and inject clears only on it or on an unlocked control write
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st <= '0;
      st.state <= C_CFG_WAIT;
      st.cpu_hold <= 1'b1;
      st.rdata <= `CTL_RESET_VALUE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ctl_rdata_o = st.rdata;
  assign cpu_hold_o = st.cpu_hold;
  assign test_clk_req_o = st.clk_req;

  // ==========================================================================
  // Assertions

  sequence s_armed_reset;
    st.state == C_RUN && sw_reset_i && st.arm;
  endsequence

  sequence s_test_held;
    st.eng_start ##1 (cpu_hold_o && test_clk_req_o && eng_busy);
  endsequence

  property p_armed_runs;
    @(posedge mclk_i) disable iff (reset_i)
      s_armed_reset |=> s_test_held;
  endproperty

  chk_armed_reset_runs: assert property (p_armed_runs)
    else $error("armed software reset did not start a held test");

  chk_done_after_test: assert property (@(posedge mclk_i) disable iff (reset_i)
    eng_done |=> ctl_rdata_o[`CTL_DONE_BIT] && !cpu_hold_o)
    else $error("done flag not shown after test end");

  chk_fail_follows: assert property (@(posedge mclk_i) disable iff (reset_i)
    eng_done && !(st.runtime && st.fault_inject)
    |=> ctl_rdata_o[`CTL_FAIL_BIT] == $past(eng_fail))
    else $error("fail flag does not match test outcome");

  chk_inject_forces: assert property (@(posedge mclk_i) disable iff (reset_i)
    eng_done && st.runtime && st.fault_inject
    |=> ctl_rdata_o[`CTL_FAIL_BIT] && ctl_rdata_o[`CTL_INJECT_BIT])
    else $error("fault inject did not force fail");

  chk_arm_self_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    eng_done |=> !ctl_rdata_o[`CTL_ARM_BIT])
    else $error("arm bit still set after test end");

  chk_startup_skip: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_CFG_WAIT && config_loaded_i && startup_selftest_disable_i
    |=> !st.eng_start ##1 !cpu_hold_o && !eng_busy)
    else $error("start-up test ran although disabled");

  chk_startup_run: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_CFG_WAIT && config_loaded_i && !startup_selftest_disable_i
    |=> st.eng_start && cpu_hold_o)
    else $error("start-up test did not launch before execution");

  chk_locked_ignored: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_RUN && ctl_wr_i && !unlocked && !sw_reset_i
    |=> $stable(st.arm) && $stable(st.fault_inject))
    else $error("locked control write changed a bit");

  chk_one_bit_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_RUN && ctl_wr_i && !sw_reset_i && !st.arm && !st.fault_inject
    && ctl_wdata_i[`CTL_ARM_BIT] && ctl_wdata_i[`CTL_INJECT_BIT]
    |=> !st.arm && !st.fault_inject)
    else $error("one unlock set two control bits");

  chk_flags_keep: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_RUN && sw_reset_i && !st.arm
    |=> cpu_hold_o && $stable(st.done_flag) && $stable(st.fault_inject))
    else $error("software reset disturbed sticky flags");

  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_rdata_o & `CTL_RESERVED_MASK) == 16'h0000)
    else $error("unimplemented control bits read nonzero");

  chk_hold_while_busy: assert property (@(posedge mclk_i) disable iff (reset_i)
    eng_busy |-> cpu_hold_o && test_clk_req_o)
    else $error("processor released while RAM under test");

  // Nothing may run, and the processor stays parked, until configuration is in
  chk_cfg_wait_held: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_CFG_WAIT |-> cpu_hold_o && !test_clk_req_o && !eng_busy)
    else $error("processor free or test running before configuration load");

  // The RAM port is silent whenever no test is under way
  chk_ram_quiet_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    !eng_busy |-> !ram_we_o && !ram_re_o)
    else $error("RAM accessed while no test runs");

  // A plain software reset parks the processor for one cycle only
  chk_plain_reset_short: assert property (@(posedge mclk_i) disable iff (reset_i)
    st.state == C_RST |=> !cpu_hold_o && !test_clk_req_o)
    else $error("plain software reset held the processor too long");

  // The test clock is never requested while the processor runs
  chk_clk_only_held: assert property (@(posedge mclk_i) disable iff (reset_i)
    test_clk_req_o |-> cpu_hold_o)
    else $error("test clock requested with processor running");

  // Done stays set through any reset but the power-on one
  chk_done_sticky: assert property (@(posedge mclk_i) disable iff (reset_i)
    ctl_rdata_o[`CTL_DONE_BIT] |=> ctl_rdata_o[`CTL_DONE_BIT])
    else $error("done flag dropped without power-on reset");

endmodule

`default_nettype wire

// ### core/selftest_defines.svh
// Bit positions, key values and reset values of the data RAM self-test control.
`ifndef SELFTEST_DEFINES_SVH
`define SELFTEST_DEFINES_SVH

`define CTL_W 16
`define CTL_ARM_BIT 0
`define CTL_FAIL_BIT 4
`define CTL_DONE_BIT 7
`define CTL_INJECT_BIT 8
`define CTL_RESERVED_MASK 16'hfe6e
`define CTL_RESET_VALUE 16'h0000
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define RAM_ADDR_W 12
`define RAM_DATA_W 16

`endif

// ### core/selftest_pkg.sv
// Types shared by the data RAM self-test controller and its engine.
`default_nettype none
`include "selftest_defines.svh"

package selftest_pkg;

  // Controller sequence around device resets
  typedef enum logic [1:0] {
    C_CFG_WAIT = 2'b00,
    C_TEST = 2'b01,
    C_RUN = 2'b10,
    C_RST = 2'b11
  } ctl_state_e;

  // March test elements
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_FILL = 3'b001,
    M_UP = 3'b010,
    M_DOWN = 3'b011,
    M_CHECK = 3'b100
  } march_phase_e;

  typedef logic [`CTL_W-1:0] ctl_word_t;

endpackage

`default_nettype wire

// ### core/unlock_key.sv
// Key sequence tracker that opens the control register for one write.
`default_nettype none
`include "selftest_defines.svh"

module unlock_key
  import selftest_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_data_i,
  input wire logic consume_i,
  output logic unlocked_o
);

  typedef struct packed {
    logic seen_first;
    logic unlocked;
  } key_regs_s;

  key_regs_s st;
  key_regs_s next_st;

  // Any other key value breaks the pair, so both bytes must be consecutive key writes
  always_comb
  begin
    next_st = st;
    if (consume_i)
    begin
      next_st.unlocked = 1'b0;
    end
    if (key_wr_i)
    begin
      next_st.seen_first = (key_data_i == `KEY_FIRST);
      if (st.seen_first && key_data_i == `KEY_SECOND)
      begin
        next_st.unlocked = 1'b1; // A fresh unlock wins over a same-cycle consume
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign unlocked_o = st.unlocked;

endmodule

`default_nettype wire

// ### core/march_engine.sv
// March test engine that sweeps the whole data RAM and keeps one fail bit.
`default_nettype none
`include "selftest_defines.svh"

module march_engine
  import selftest_pkg::*;
#(
  parameter int ADDR_W = `RAM_ADDR_W,
  parameter int DATA_W = `RAM_DATA_W
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [DATA_W-1:0] ram_rdata_i,
  output logic [ADDR_W-1:0] ram_addr_o,
  output logic [DATA_W-1:0] ram_wdata_o,
  output logic ram_we_o,
  output logic ram_re_o,
  output logic busy_o,
  output logic done_o,
  output logic fail_o
);

  localparam logic [ADDR_W-1:0] LAST = '1;

  typedef struct packed {
    march_phase_e phase;
    logic [ADDR_W-1:0] addr;
    logic [1:0] step;
    logic fail;
    logic done;
    logic [ADDR_W-1:0] ram_addr;
    logic [DATA_W-1:0] ram_wdata;
    logic ram_we;
    logic ram_re;
  } eng_regs_s;

  eng_regs_s st;
  eng_regs_s next_st;
  logic [DATA_W-1:0] expect_word;

  // Step 0 reads, step 1 waits on the synchronous RAM, step 2 compares and, except in M_CHECK, writes back
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.ram_we = 1'b0;
    next_st.ram_re = 1'b0;
    expect_word = (st.phase == M_DOWN) ? '1 : '0;
    unique case (st.phase)
      M_IDLE:
      begin
        if (start_i)
        begin
          next_st.phase = M_FILL;
          next_st.addr = '0;
          next_st.step = 2'h0;
          next_st.fail = 1'b0;
        end
      end
      M_FILL:
      begin
        // Contents are destroyed everywhere, stack area included
        next_st.ram_addr = st.addr;
        next_st.ram_wdata = '0;
        next_st.ram_we = 1'b1;
        next_st.addr = st.addr + ADDR_W'(1);
        if (st.addr == LAST)
        begin
          next_st.phase = M_UP;
          next_st.addr = '0;
        end
      end
      M_UP, M_DOWN, M_CHECK:
      begin
        next_st.step = st.step + 2'h1;
        if (st.step == 2'h0)
        begin
          next_st.ram_addr = st.addr;
          next_st.ram_re = 1'b1;
        end
        else if (st.step == 2'h2)
        begin
          next_st.step = 2'h0;
          // Only a sticky flag; the failing address is deliberately not kept
          if (ram_rdata_i != expect_word)
          begin
            next_st.fail = 1'b1;
          end
          next_st.ram_we = (st.phase != M_CHECK);
          next_st.ram_wdata = (st.phase == M_UP) ? '1 : '0;
          if (st.phase == M_DOWN)
          begin
            next_st.addr = st.addr - ADDR_W'(1);
            if (st.addr == '0)
            begin
              next_st.phase = M_CHECK;
            end
          end
          else
          begin
            next_st.addr = st.addr + ADDR_W'(1);
            if (st.addr == LAST)
            begin
              next_st.phase = (st.phase == M_UP) ? M_DOWN : M_IDLE;
              next_st.addr = (st.phase == M_UP) ? LAST : '0;
              next_st.done = (st.phase == M_CHECK);
            end
          end
        end
      end
      default:
      begin
        next_st.phase = M_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ram_addr_o = st.ram_addr;
  assign ram_wdata_o = st.ram_wdata;
  assign ram_we_o = st.ram_we;
  assign ram_re_o = st.ram_re;
  assign busy_o = (st.phase != M_IDLE);
  assign done_o = st.done;
  assign fail_o = st.fail;

endmodule

`default_nettype wire

// ### bench/data_ram_model.sv
// Behavioural synchronous data RAM facing the self-test engine.
`default_nettype none

module data_ram_model
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 16
)
(
  input wire logic mclk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic fault_i,
  output logic [DATA_W-1:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // =========================================================
  // Storage with one optional stuck-at-one cell
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BAD_ADDR = 5;
  logic [DATA_W-1:0] mem [DEPTH];

  // Nonzero start contents, so a skipped fill shows up
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] = DATA_W'(i * 16'h0303 + 16'h00a5);
    rdata_o = '0;
  end

  // One-cycle read; data line toggles when no read, never holds stale data
  always @(posedge mclk_i)
  begin
    if (we_i)
      mem[addr_i] <= (fault_i && addr_i == ADDR_W'(BAD_ADDR)) ? wdata_i | DATA_W'(1) : wdata_i;
    if (re_i)
      rdata_o <= mem[addr_i];
    else
      rdata_o <= ~rdata_o;
  end
endmodule

`default_nettype wire

// ### bench/data_ram_selftest_controller_tb.sv
// Self-checking bench for the data RAM self-test controller.
`default_nettype none
`include "selftest_defines.svh"

module data_ram_selftest_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import selftest_pkg::*;

  localparam int AW = 4;
  localparam int DW = 16;
  logic mclk, reset_i, sw_reset, cfg_loaded, start_dis, key_wr, ctl_wr, ram_fault;
  logic [7:0] key_data;
  ctl_word_t ctl_wdata, ctl_rdata;
  logic [DW-1:0] ram_rdata, ram_wdata;
  logic [AW-1:0] ram_addr;
  logic ram_we, ram_re, cpu_hold, clk_req;
  int mismatches = 0;
  int comparisons = 0;

  // =========================================================
  // Design, RAM and clock
  memory_selftest_ctrl #(.ADDR_W(AW), .DATA_W(DW)) dut_u
  (
    .mclk_i(mclk),
    .reset_i(reset_i),
    .sw_reset_i(sw_reset),
    .config_loaded_i(cfg_loaded),
    .startup_selftest_disable_i(start_dis),
    .key_wr_i(key_wr),
    .key_data_i(key_data),
    .ctl_wr_i(ctl_wr),
    .ctl_wdata_i(ctl_wdata),
    .ram_rdata_i(ram_rdata),
    .ctl_rdata_o(ctl_rdata),
    .cpu_hold_o(cpu_hold),
    .test_clk_req_o(clk_req),
    .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata),
    .ram_we_o(ram_we),
    .ram_re_o(ram_re)
  );

  data_ram_model #(.ADDR_W(AW), .DATA_W(DW)) ram_u
  (
    .mclk_i(mclk),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .we_i(ram_we),
    .re_i(ram_re),
    .fault_i(ram_fault),
    .rdata_o(ram_rdata)
  );

  // 200 MHz
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // =========================================================
  // Shared tasks
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic key_write(input logic [7:0] k);
    key_data = k;
    key_wr = 1'b1;
    step();
    key_wr = 1'b0;
    step();
  endtask

  task automatic ctl_write(input logic [15:0] d);
    ctl_wdata = d;
    ctl_wr = 1'b1;
    step();
    ctl_wr = 1'b0;
    step();
  endtask

  task automatic unlock();
    key_write(`KEY_FIRST);
    key_write(`KEY_SECOND);
  endtask

  // Called just after the launching edge; follows the test to its end
  task automatic finish_test(input logic exp_req, input logic [15:0] exp_seen,
                             input logic [15:0] exp_ctl);
    int n;
    logic [15:0] seen;
    n = 0;
    seen = '0;
    step();
    if (exp_req) check("hold_start", 16'h0001, cpu_hold);
    check("clk_req", exp_req, clk_req);
    // Bounded, since a stuck hold would otherwise hang the run
    while (cpu_hold === 1'b1 && n < 3000)
    begin
      if (ram_we === 1'b1) seen[ram_addr] = 1'b1;
      step();
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      complete_run();
    end
    check("coverage", exp_seen, seen);
    check("clk_req_end", 16'h0000, clk_req);
    check("ctl_after", exp_ctl, ctl_rdata);
  endtask

  task automatic run_test(input logic [15:0] exp_ctl);
    sw_reset = 1'b1;
    step();
    sw_reset = 1'b0;
    finish_test(1'b1, 16'hffff, exp_ctl);
  endtask

  // =========================================================
  // Scenarios
  task automatic power_on(input logic dis, input logic req, input logic [15:0] seen,
                          input logic [15:0] ctl);
    reset_i = 1'b1;
    start_dis = dis;
    step(6);
    reset_i = 1'b0;
    check("ctl_por", 16'h0000, ctl_rdata);
    step(3);
    check("hold_cfg", 16'h0001, cpu_hold);
    cfg_loaded = 1'b1;
    step();
    cfg_loaded = 1'b0;
    finish_test(req, seen, ctl);
  endtask

  task automatic plain_reset(input logic [15:0] exp_ctl);
    sw_reset = 1'b1;
    step();
    sw_reset = 1'b0;
    check("hold_sw", 16'h0001, cpu_hold);
    step();
    check("hold_free", 16'h0000, cpu_hold);
    check("ctl_sw", exp_ctl, ctl_rdata);
  endtask

  task automatic locked_writes();
    ctl_write(16'h0001);
    check("locked", 16'h0000, ctl_rdata);
    key_write(`KEY_FIRST);
    key_write(8'h12);
    key_write(`KEY_SECOND);
    ctl_write(16'h0001);
    check("broken_key", 16'h0000, ctl_rdata);
    unlock();
    ctl_write(16'h0101);
    check("two_bits", 16'h0000, ctl_rdata);
    unlock();
    ctl_write(16'hfeff);
    check("arm_only", 16'h0001, ctl_rdata);
    ctl_write(16'h0000);
    check("relocked", 16'h0001, ctl_rdata);
  endtask

  task automatic run_time_pass();
    run_test(16'h0080);
    for (int i = 0; i < 16; i++)
      check("ram_word", 16'h0000, ram_u.mem[i]);
  endtask

  task automatic fault_sim();
    unlock();
    ctl_write(16'h0001);
    unlock();
    ctl_write(16'h0101);
    check("armed_inject", 16'h0181, ctl_rdata);
    run_test(16'h0190);
    plain_reset(16'h0190);
  endtask

  task automatic real_fail();
    unlock();
    ctl_write(16'h0000);
    check("inject_off", 16'h0090, ctl_rdata);
    ram_fault = 1'b1;
    unlock();
    ctl_write(16'h0001);
    run_test(16'h0090);
    ram_fault = 1'b0;
    unlock();
    ctl_write(16'h0001);
    run_test(16'h0080);
  endtask

  // =========================================================
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    sw_reset = 1'b0;
    cfg_loaded = 1'b0;
    start_dis = 1'b1;
    key_wr = 1'b0;
    ctl_wr = 1'b0;
    ram_fault = 1'b0;
    key_data = '0;
    ctl_wdata = '0;
    power_on(1'b1, 1'b0, 16'h0000, 16'h0000);
    locked_writes();
    unlock();
    ctl_write(16'h0001);
    run_time_pass();
    fault_sim();
    real_fail();
    power_on(1'b0, 1'b1, 16'hffff, 16'h0080);
    complete_run();
  end
endmodule

`default_nettype wire
